/* pkg/cra_pkg.sv */
// Purpose: shared constants and types for the cell converter result readout
// Assumes: one 40 MHz clock, byte-wide register port
// Notes: result pair of channel c sits at 1+2c (high) and 2+2c (low)
package cra_pkg;
   // ----------------------------------------
   // clock and data widths
   // ----------------------------------------
   localparam int CLK_HZ = 40000000;
   localparam int RES_W = 14;
   localparam logic [13:0] RES_MAX = 14'h3FFF;
   localparam int CELL_MV_FS = 6250;
   localparam int CELL_CODE_FS = 16383;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] AUX_RESULT_HIGH_OFS = 8'h01;
   localparam logic [7:0] CELL_ONE_RESULT_HIGH_OFS = 8'h03;
   localparam logic [7:0] CELL_ONE_RESULT_LOW_OFS = 8'h04;
   localparam logic [7:0] LAST_RESULT_OFS = 8'h12;
   localparam logic [7:0] SOFTWARE_TRIGGER_BIT_SETUP_OFS = 8'h30;
   localparam logic [7:0] SOFTWARE_TRIGGER_BIT_CTRL_OFS = 8'h31;
   localparam logic [7:0] FUNC_CFG_OFS = 8'h32;

   // ----------------------------------------
   // field positions and reset values
   // ----------------------------------------
   localparam int CELL_COUNT_LSB = 0;
   localparam int TS1_EN_BIT = 4;
   localparam int TS2_EN_BIT = 5;
   localparam int AUX_EN_BIT = 6;
   localparam int SW_TRIG_BIT = 0;
   localparam int AUX_SRC_BIT = 0;
   localparam logic [2:0] CELL_COUNT_RST = 3'h5;

   // ----------------------------------------
   // converter channel codes
   // ----------------------------------------
   localparam logic [3:0] CH_AUX = 4'h0;
   localparam logic [3:0] CH_CELL1 = 4'h1;
   localparam logic [3:0] CH_TS1 = 4'h7;
   localparam logic [3:0] CH_TS2 = 4'h8;
   localparam logic [3:0] CH_BRICK = 4'h9;
   localparam int NUM_RES = 9;
   localparam int NUM_SEQ = 9;

   typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT, ST_NEXT} cra_state_t;

   typedef struct packed {
      logic aux_en;
      logic ts2_en;
      logic ts1_en;
      logic [2:0] cell_count;
   } cra_setup_t;
endpackage

/* logic/cra_readout.sv */
// Purpose: sequencing, saturation and byte readout of converter results
// Assumes: converter handshake on sys_clk; host trigger pin is asynchronous
// Notes: register reads answer one cycle after the read strobe
module cra_readout
   import cra_pkg::*;
#(
   parameter logic signed [15:0] TRIM = 16'sh0000
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // trigger pins
   input wire logic host_trigger_pin,
   output logic upward_trigger_pin,
   // converter core
   output logic adc_start,
   output logic [3:0] adc_channel,
   input wire logic adc_done,
   input wire logic [13:0] adc_raw,
   // status
   output logic busy
);
   // ----------------------------------------
   // control registers
   // ----------------------------------------
   cra_setup_t setup_reg;
   logic aux_source_select;
   logic software_trigger_bit;
   cra_state_t state_reg;
   logic [3:0] seq_reg;
   logic [13:0] res_mem [NUM_RES];
   logic [7:0] rd_addr_reg;
   logic trig_s1, trig_s2, trig_s3;
   logic host_rise, sw_wr1, go;
   logic [4:0] nxt;
   logic signed [15:0] corr;
   logic [13:0] sat_res;
   logic [3:0] cur_ch;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         setup_reg <= '{aux_en: 1'b0, ts2_en: 1'b0, ts1_en: 1'b0, cell_count: CELL_COUNT_RST};
         aux_source_select <= 1'b0;
      end else if (reg_wr && reg_addr == SOFTWARE_TRIGGER_BIT_SETUP_OFS) begin
         setup_reg <= '{aux_en: reg_wdata[AUX_EN_BIT], ts2_en: reg_wdata[TS2_EN_BIT],
                        ts1_en: reg_wdata[TS1_EN_BIT], cell_count: reg_wdata[CELL_COUNT_LSB +: 3]};
      end else if (reg_wr && reg_addr == FUNC_CFG_OFS) begin
         aux_source_select <= reg_wdata[AUX_SRC_BIT];
      end
   end

   // ----------------------------------------
   // trigger sources
   // ----------------------------------------
   // two flops before use; third only feeds the edge detector
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         trig_s1 <= 1'b0;
         trig_s2 <= 1'b0;
         trig_s3 <= 1'b0;
         upward_trigger_pin <= 1'b0;
      end else begin
         trig_s1 <= host_trigger_pin;
         trig_s2 <= trig_s1;
         trig_s3 <= trig_s2;
         upward_trigger_pin <= trig_s2;
      end
   end

   // a held-high pin blocks the software bit, as on the real part
   assign host_rise = trig_s2 && !trig_s3;
   assign sw_wr1 = reg_wr && reg_addr == SOFTWARE_TRIGGER_BIT_CTRL_OFS && reg_wdata[SW_TRIG_BIT] && !trig_s2;
   assign go = state_reg == ST_IDLE && (host_rise || sw_wr1);

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         software_trigger_bit <= 1'b0;
      end else if (sw_wr1) begin
         software_trigger_bit <= 1'b1;
      end else if (state_reg == ST_NEXT && nxt[4]) begin
         software_trigger_bit <= 1'b0;
      end
   end

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   // slot order: cells 0..5, ts1, ts2, aux; bit 4 of result means done
   function automatic logic [4:0] find_next(input logic [3:0] from, input cra_setup_t s);
      logic [4:0] r;
      logic en;
      r = 5'h10;
      for (int i = NUM_SEQ - 1; i >= 0; i--) begin
         if (i < 6) begin
            en = (i <= int'(s.cell_count));
         end else if (i == 6) begin
            en = s.ts1_en;
         end else if (i == 7) begin
            en = s.ts2_en;
         end else begin
            en = s.aux_en;
         end
         if (en && i >= int'(from)) begin
            r = {1'b0, 4'(i)};
         end
      end
      return r;
   endfunction

   always_comb begin
      nxt = find_next(state_reg == ST_IDLE ? 4'h0 : 4'(seq_reg + 4'h1), setup_reg);
      if (seq_reg < 4'h6) begin
         cur_ch = 4'(seq_reg + CH_CELL1);
      end else if (seq_reg == 4'h6) begin
         cur_ch = CH_TS1;
      end else if (seq_reg == 4'h7) begin
         cur_ch = CH_TS2;
      end else begin
         cur_ch = CH_AUX;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
         seq_reg <= 4'h0;
         busy <= 1'b0;
         adc_start <= 1'b0;
         adc_channel <= CH_AUX;
      end else begin
         adc_start <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (go && !nxt[4]) begin
                  seq_reg <= nxt[3:0];
                  state_reg <= ST_START;
                  busy <= 1'b1;
               end
            end
            ST_START: begin
               adc_start <= 1'b1;
               adc_channel <= (cur_ch == CH_AUX && aux_source_select) ? CH_BRICK : cur_ch;
               state_reg <= ST_WAIT;
            end
            ST_WAIT: begin
               if (adc_done) begin
                  state_reg <= ST_NEXT;
               end
            end
            ST_NEXT: begin
               if (nxt[4]) begin
                  state_reg <= ST_IDLE;
                  busy <= 1'b0;
               end else begin
                  seq_reg <= nxt[3:0];
                  state_reg <= ST_START;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // result store
   // ----------------------------------------
   // clamp instead of wrap so a near-zero reading never turns huge
   always_comb begin
      corr = $signed({2'b00, adc_raw}) + TRIM;
      if (corr < 16'sh0000) begin
         sat_res = 14'h0000;
      end else if (corr > $signed({2'b00, RES_MAX})) begin
         sat_res = RES_MAX;
      end else begin
         sat_res = corr[13:0];
      end
   end

   // cell codes are linear: mV = code * CELL_MV_FS / CELL_CODE_FS
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < NUM_RES; i++) begin
            res_mem[i] <= 14'h0000;
         end
      end else if (state_reg == ST_WAIT && adc_done) begin
         res_mem[cur_ch] <= sat_res;
      end
   end

   // ----------------------------------------
   // register readout
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
         rd_addr_reg <= 8'h00;
      end else begin
         reg_rvalid <= reg_rd;
         rd_addr_reg <= reg_addr;
         if (!reg_rd) begin
            reg_rdata <= 8'h00;
         end else if (reg_addr >= AUX_RESULT_HIGH_OFS && reg_addr <= LAST_RESULT_OFS) begin
            // odd offsets hold the high byte of a pair
            if (reg_addr[0]) begin
               reg_rdata <= {2'b00, res_mem[4'((reg_addr - 8'h01) >> 1)][13:8]};
            end else begin
               reg_rdata <= res_mem[4'((reg_addr - 8'h02) >> 1)][7:0];
            end
         end else if (reg_addr == SOFTWARE_TRIGGER_BIT_SETUP_OFS) begin
            reg_rdata <= {1'b0, setup_reg.aux_en, setup_reg.ts2_en, setup_reg.ts1_en, 1'b0,
                          setup_reg.cell_count};
         end else if (reg_addr == SOFTWARE_TRIGGER_BIT_CTRL_OFS) begin
            reg_rdata <= {7'h00, software_trigger_bit};
         end else if (reg_addr == FUNC_CFG_OFS) begin
            reg_rdata <= {7'h00, aux_source_select};
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   sequence rise_seen;
      !trig_s3 && trig_s2 && state_reg == ST_IDLE;
   endsequence
   sequence cycle_opens;
      busy && state_reg == ST_START ##1 adc_start;
   endsequence

   msb_zero_a: assert property (reg_rvalid && rd_addr_reg[0] && rd_addr_reg <= LAST_RESULT_OFS
      |-> reg_rdata[7:6] == 2'b00) else $error("result high byte top bits set");
   cell_pair_a: assert property (reg_rd && reg_addr == CELL_ONE_RESULT_HIGH_OFS
      |=> reg_rdata == {2'b00, $past(res_mem[1][13:8])}) else $error("cell one high byte wrong");
   cell_low_a: assert property (reg_rd && reg_addr == CELL_ONE_RESULT_LOW_OFS
      |=> reg_rdata == $past(res_mem[1][7:0])) else $error("cell one low byte wrong");
   sat_low_a: assert property (state_reg == ST_WAIT && adc_done && corr < 0
      |=> res_mem[$past(cur_ch)] == 14'h0000) else $error("underflow wrapped");
   sat_high_a: assert property (state_reg == ST_WAIT && adc_done && corr > 16'sh3FFF
      |=> res_mem[$past(cur_ch)] == RES_MAX) else $error("overflow wrapped");
   hw_start_a: assert property (rise_seen and (!nxt[4]) |=> cycle_opens)
      else $error("pin edge did not start");
   sw_start_a: assert property (sw_wr1 && state_reg == ST_IDLE && !nxt[4]
      |=> software_trigger_bit && busy) else $error("software start lost");
   sw_clear_a: assert property ($fell(busy) |-> !software_trigger_bit)
      else $error("trigger bit not cleared");
   cell_skip_a: assert property (adc_start && adc_channel >= CH_CELL1 && adc_channel < CH_TS1
      |-> adc_channel <= {1'b0, setup_reg.cell_count} + 4'h1) else $error("unused cell scanned");
   aux_src_a: assert property (adc_start && (adc_channel == CH_AUX || adc_channel == CH_BRICK)
      |-> (adc_channel == CH_BRICK) == aux_source_select) else $error("aux source wrong");
   hold_a: assert property (!(state_reg == ST_WAIT && adc_done) |=> $stable(res_mem[1]))
      else $error("result changed without conversion");
endmodule

/* sim/cra_adc_model.sv */
// Purpose: converter core stand-in answering start pulses
// Assumes: same clock as the readout block
// Notes: raw bus toggles except on start and done cycles so stale codes never match
module cra_adc_model
   import cra_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // converter side
   input wire logic adc_start,
   input wire logic [3:0] adc_channel,
   input wire logic [3:0] lat,
   input wire logic [9:0][13:0] codes,
   output logic adc_done,
   output logic [13:0] adc_raw
);
   timeunit 1ns;
   timeprecision 1ps;
   logic run;
   logic [3:0] cnt;
   logic [3:0] ch;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         run <= 1'b0;
         cnt <= 4'h0;
         ch <= 4'h0;
         adc_done <= 1'b0;
         adc_raw <= 14'h0000;
      end else begin
         adc_done <= 1'b0;
         if (adc_start) begin
            run <= 1'b1;
            cnt <= lat;
            ch <= adc_channel;
         end else if (run && cnt == 4'h0) begin
            run <= 1'b0;
            adc_done <= 1'b1;
            adc_raw <= codes[ch];
         end else begin
            cnt <= cnt - 4'h1;
            adc_raw <= ~adc_raw;
         end
      end
   end
endmodule

/* sim/cell_adc_result_readout_bench.sv */
// Purpose: random and corner runs of trigger, scan and readout
// Assumes: offset trim of +16 so the top end saturates
// Notes: inputs move on the falling edge
module cell_adc_result_readout_bench
   import cra_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, nrst, reg_wr, reg_rd, reg_rvalid, host_trigger_pin, upward_trigger_pin;
   logic adc_start, adc_done, busy;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d, setup;
   logic [3:0] adc_channel, lat;
   logic [13:0] adc_raw;
   logic [9:0][13:0] codes;
   logic [13:0] exp_mem [0:8];
   logic [3:0] expq [$];
   logic [3:0] seen [$];
   logic [31:0] rnd = 32'hBA26920E;
   int fails = 0, n_checks = 0, n;
   cra_readout #(.TRIM(16'sh0010)) u_dut (.sys_clk(sys_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .host_trigger_pin(host_trigger_pin), .upward_trigger_pin(upward_trigger_pin), .adc_start(adc_start),
      .adc_channel(adc_channel), .adc_done(adc_done), .adc_raw(adc_raw), .busy(busy));
   cra_adc_model u_adc (.sys_clk(sys_clk), .nrst(nrst), .adc_start(adc_start), .adc_channel(adc_channel),
      .lat(lat), .codes(codes), .adc_done(adc_done), .adc_raw(adc_raw));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [13:0] sat(input logic [13:0] r);
      return (r > 14'h3FEF) ? 14'h3FFF : r + 14'h0010;
   endfunction
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return v[0] ? (v >> 1) ^ 32'hA3000000 : v >> 1;
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected byte at %0t: %h not %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected flag at %0t: %b not %b", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge sys_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = v;
      @(negedge sys_clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(negedge sys_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      d = reg_rdata;
      chk1(reg_rvalid, 1'b1);
   endtask
   task automatic wait_busy(input logic v);
      for (int i = 0; i < 3000 && busy !== v; i++) @(negedge sys_clk);
   endtask
   always @(posedge sys_clk) if (adc_start === 1'b1) seen.push_back(adc_channel);
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   initial begin
      #2000000;
      fails++;
      complete_run();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {nrst, reg_wr, reg_rd, host_trigger_pin, reg_addr, reg_wdata, lat, codes} = '0;
      for (int c = 0; c < 9; c++) exp_mem[c] = 14'h0000;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      nrst = 1'b1;
      for (int r = 0; r < 14; r++) begin
         rnd = lfsr(rnd);
         setup = {1'b0, rnd[6:4], 1'b0, rnd[2:0]};
         lat = rnd[11:8];
         for (int c = 0; c < 10; c++) begin
            rnd = lfsr(rnd);
            codes[c] = r == 0 ? 14'h3FFF : r == 1 ? 14'h0000 : r == 2 ? 14'h3FEF : rnd[13:0];
         end
         wr(SOFTWARE_TRIGGER_BIT_SETUP_OFS, setup);
         wr(FUNC_CFG_OFS, {7'h00, rnd[20]});
         n = setup[2:0] > 3'h4 ? 6 : int'(setup[2:0]) + 1;
         expq.delete();
         seen.delete();
         for (int i = 1; i <= n; i++) expq.push_back(4'(i));
         if (setup[4]) expq.push_back(CH_TS1);
         if (setup[5]) expq.push_back(CH_TS2);
         if (setup[6]) expq.push_back(rnd[20] ? CH_BRICK : CH_AUX);
         if (r[0]) host_trigger_pin = 1'b1;
         else wr(SOFTWARE_TRIGGER_BIT_CTRL_OFS, 8'h01);
         wait_busy(1'b1);
         chk1(busy, 1'b1);
         rd(SOFTWARE_TRIGGER_BIT_CTRL_OFS);
         chk1(d[0], !r[0]);
         wait_busy(1'b0);
         chk1(busy, 1'b0);
         chk1(upward_trigger_pin, r[0]);
         host_trigger_pin = 1'b0;
         rd(SOFTWARE_TRIGGER_BIT_CTRL_OFS);
         chk1(d[0], 1'b0);
         chk8(8'(seen.size()), 8'(expq.size()));
         foreach (expq[i]) chk8({4'h0, seen[i]}, {4'h0, expq[i]});
         foreach (expq[i]) exp_mem[expq[i] == CH_BRICK ? 0 : expq[i]] = sat(codes[expq[i]]);
         for (int c = 0; c < 9; c++) begin
            rd(8'(1 + 2 * c));
            chk8(d, {2'b00, exp_mem[c][13:8]});
            rd(8'(2 + 2 * c));
            chk8(d, exp_mem[c][7:0]);
         end
         repeat (4) @(negedge sys_clk);
         chk1(upward_trigger_pin, 1'b0);
      end
      wr(SOFTWARE_TRIGGER_BIT_CTRL_OFS, 8'h00);
      repeat (4) @(negedge sys_clk);
      chk1(busy, 1'b0);
      wr(CELL_ONE_RESULT_HIGH_OFS, 8'hAA);
      rd(CELL_ONE_RESULT_HIGH_OFS);
      chk8(d, {2'b00, exp_mem[1][13:8]});
      rd(8'hFF);
      chk8(d, 8'h00);
      complete_run();
   end
endmodule
